/* rtl/rpc_pkg.sv */
// Shared constants, types and helpers of the RMS and power calculator.
package rpc_pkg;
    // ************************************************************
    // Timing
    // ************************************************************
    localparam int CLK_HZ = 40_000_000;
    localparam int CLK_PERIOD_NS = 25;
    localparam int SAMPLE_HZ = 14400;
    localparam real SAMPLE_PERIOD_US = 69.44;
    localparam int TICK_CYCLES = CLK_HZ / SAMPLE_HZ;
    localparam int QSIGN_RATE_HZ = 240;
    localparam int INT_MS_100 = 100;
    localparam int INT_MS_200 = 200;
    localparam int INT_MS_500 = 500;
    localparam int INT_MS_1000 = 1000;
    localparam int MS_PER_S = 1000;

    // ************************************************************
    // Channels, widths and result layout
    // ************************************************************
    localparam int NCH = 4;
    localparam int NQ = 5;
    localparam int VW = 16;
    localparam int IW = 20;
    localparam int CNT_W = 14;
    localparam int RW = 2 * (VW + IW);
    localparam int RECIP_SHIFT = 40;
    localparam int Q_VRMS = 0;
    localparam int Q_IRMS = 1;
    localparam int Q_SRMS = 2;
    localparam int Q_PRMS = 3;
    localparam int Q_NRMS = 4;
    localparam int FLOAT_BIAS = 127;
    localparam int FLOAT_MANT = 23;
    localparam int ADDR_W = 5;

    typedef enum logic [1:0] {INT_100MS, INT_200MS, INT_500MS, INT_1S} rpc_int_e;

    typedef logic [31:0] rpc_float_t;

    typedef struct packed {
        logic [NCH-1:0][VW-1:0] volt;
        logic [NCH-1:0][IW-1:0] curr;
    } rpc_sample_s;

    typedef struct packed {
        rpc_float_t [NCH*NQ-1:0] val;
    } rpc_report_s;

    function automatic int windowLen(rpc_int_e sel);
        case (sel)
            INT_100MS: return INT_MS_100 * SAMPLE_HZ / MS_PER_S;
            INT_200MS: return INT_MS_200 * SAMPLE_HZ / MS_PER_S;
            INT_500MS: return INT_MS_500 * SAMPLE_HZ / MS_PER_S;
            default: return INT_MS_1000 * SAMPLE_HZ / MS_PER_S;
        endcase
    endfunction

    function automatic logic [63:0] recipOf(rpc_int_e sel);
        logic [63:0] n;
        n = 64'(windowLen(sel));
        return ((64'h1 << RECIP_SHIFT) + (n >> 1)) / n;
    endfunction
endpackage

/* rtl/rpc_isqrt.sv */
// Iterative integer square root, two radicand bits per clock.
`timescale 1ns/1ps
`default_nettype none
module rpc_isqrt
    import rpc_pkg::*;
#(
    parameter int W = RW
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic start,
    input wire logic [W-1:0] radicand,
    output logic done,
    output logic [W/2-1:0] root
);
    localparam int HW = W / 2;
    logic [W-1:0] x;
    logic [W-1:0] xHeld;
    logic [HW+2:0] rem;
    logic [$clog2(HW+1)-1:0] steps;
    logic busy;
    logic [HW+2:0] shifted;
    logic [HW+2:0] trial;

    assign shifted = {rem[HW:0], x[W-1 -: 2]};
    assign trial = {1'b0, root, 2'b01};

    always_ff @(posedge clk) begin
        if (srst) begin
            busy <= 1'b0;
            done <= 1'b0;
            rem <= '0;
            root <= '0;
            x <= '0;
            xHeld <= '0;
            steps <= '0;
        end else begin
            done <= 1'b0;
            if (start && !busy) begin
                busy <= 1'b1;
                x <= radicand;
                xHeld <= radicand;
                rem <= '0;
                root <= '0;
                steps <= ($clog2(HW+1))'(HW);
            end else if (busy) begin
                x <= x << 2;
                if (shifted >= trial) begin
                    rem <= shifted - trial;
                    root <= {root[HW-2:0], 1'b1};
                end else begin
                    rem <= shifted;
                    root <= {root[HW-2:0], 1'b0};
                end
                steps <= steps - 1'b1;
                if (steps == 1) begin
                    busy <= 1'b0;
                    done <= 1'b1;
                end
            end
        end
    end

    // ************************************************************
    // Checks
    // ************************************************************
    property p_rootExact;
        @(posedge clk) disable iff (srst)
        done |-> ((W+2)'(root) * (W+2)'(root) <= (W+2)'(xHeld))
            && (((W+2)'(root) + 1) * ((W+2)'(root) + 1) > (W+2)'(xHeld));
    endproperty
    a_rootExact: assert property (p_rootExact) else $error("root is not floor sqrt");
endmodule
`default_nettype wire

/* rtl/rpc_calc.sv */
// Windowed RMS voltage, current and power calculator for four channels.
// ************************************************************
// Summary of operation
// - One sample per channel is taken 14400 times a second.
// - Window length N follows the 100 ms, 200 ms, 500 ms or 1 s setting.
// - Five quantities are produced for phases A, B, C and neutral.
// - RMS current is the root of the mean squared current over N.
// - Apparent power is root of the product of mean squared voltage and current over N.
// - Active power is the mean of simultaneous voltage-current products.
// - Non-active power is root of S squared minus P squared, signed by Q.
// - Results leave for the stream only as single precision floats.
// - Register map copies refresh once per window, in the same cycle as the stream output.
// ************************************************************
`timescale 1ns/1ps
`default_nettype none
module rpc_calc
    import rpc_pkg::*;
#(
    parameter int TICKS = TICK_CYCLES
) (
    input wire logic clk,
    input wire logic srst,
    input wire rpc_int_e intSel,
    input wire rpc_sample_s samples,
    input wire logic qUpdate,
    input wire logic [NCH-1:0] qNegative,
    input wire logic [ADDR_W-1:0] mapAddr,
    output logic sampleReq,
    output logic streamValid,
    output rpc_report_s streamData,
    output rpc_float_t mapData
);
    localparam int HW = RW / 2;

    typedef enum {S_IDLE, S_PREP, S_ROOT, S_WAIT, S_PUBLISH} rpc_state_e;

    function automatic rpc_float_t toFloat(logic [RW-1:0] mag, logic neg);
        logic [RW-1:0] norm;
        int msb;
        msb = -1;
        for (int b = 0; b < RW; b++) begin
            if (mag[b]) begin
                msb = b;
            end
        end
        if (msb < 0) begin
            return 32'h0;
        end
        norm = mag << (RW - 1 - msb);
        return {neg, 8'(FLOAT_BIAS + msb), norm[RW-2 -: FLOAT_MANT]};
    endfunction

    function automatic logic [RW-1:0] meanOf(logic [63:0] sum, logic [63:0] recip);
        logic [127:0] prod;
        prod = 128'(sum) * 128'(recip);
        return RW'(prod >> RECIP_SHIFT);
    endfunction

    // ************************************************************
    // Sample rate divider and window counter
    // ************************************************************
    logic [$clog2(TICKS)-1:0] tickCnt;
    logic [CNT_W-1:0] sampleCnt;
    logic [CNT_W-1:0] winLen;
    logic [63:0] recip;
    logic windowEnd;

    assign sampleReq = (tickCnt == ($clog2(TICKS))'(TICKS - 1));
    assign windowEnd = sampleReq && (sampleCnt == winLen - 1'b1);

    always_ff @(posedge clk) begin
        if (srst || sampleReq) begin
            tickCnt <= '0;
        end else begin
            tickCnt <= tickCnt + 1'b1;
        end
    end

    // The setting is only taken at a window boundary so a change never splits a window.
    always_ff @(posedge clk) begin
        if (srst) begin
            sampleCnt <= '0;
            winLen <= CNT_W'(windowLen(INT_100MS));
        end else if (windowEnd) begin
            sampleCnt <= '0;
            winLen <= CNT_W'(windowLen(intSel));
        end else if (sampleReq) begin
            sampleCnt <= sampleCnt + 1'b1;
        end
    end

    // ************************************************************
    // Accumulators
    // ************************************************************
    logic [NCH-1:0][2*VW+CNT_W-1:0] accVV;
    logic [NCH-1:0][2*IW+CNT_W-1:0] accII;
    logic [NCH-1:0][VW+IW+CNT_W-1:0] accVI;
    logic [NCH-1:0][63:0] sumVV;
    logic [NCH-1:0][63:0] sumII;
    logic [NCH-1:0][63:0] sumVI;
    logic [NCH-1:0][2*VW+CNT_W-1:0] nextVV;
    logic [NCH-1:0][2*IW+CNT_W-1:0] nextII;
    logic [NCH-1:0][VW+IW+CNT_W-1:0] nextVI;

    always_comb begin
        for (int c = 0; c < NCH; c++) begin
            nextVV[c] = accVV[c] + (2*VW+CNT_W)'($signed(samples.volt[c]) * $signed(samples.volt[c]));
            nextII[c] = accII[c] + (2*IW+CNT_W)'($signed(samples.curr[c]) * $signed(samples.curr[c]));
            nextVI[c] = accVI[c]
                + (VW+IW+CNT_W)'($signed(samples.volt[c]) * $signed(samples.curr[c]));
        end
    end

    always_ff @(posedge clk) begin
        if (srst || windowEnd) begin
            accVV <= '0;
            accII <= '0;
            accVI <= '0;
        end else if (sampleReq) begin
            accVV <= nextVV;
            accII <= nextII;
            accVI <= nextVI;
        end
    end

    // The last sample of a window goes into the frozen sums, not the cleared accumulators.
    always_ff @(posedge clk) begin
        if (srst) begin
            sumVV <= '0;
            sumII <= '0;
            sumVI <= '0;
            recip <= '0;
        end else if (windowEnd) begin
            for (int c = 0; c < NCH; c++) begin
                sumVV[c] <= 64'(nextVV[c]);
                sumII[c] <= 64'(nextII[c]);
                sumVI[c] <= 64'($signed(nextVI[c]));
            end
            recip <= recipOf(rpc_int_e'(windowLen(INT_100MS) == 32'(winLen) ? INT_100MS :
                      windowLen(INT_200MS) == 32'(winLen) ? INT_200MS :
                      windowLen(INT_500MS) == 32'(winLen) ? INT_500MS : INT_1S));
        end
    end

    // ************************************************************
    // Reactive sign tracking
    // ************************************************************
    logic [NCH-1:0] qHeld;
    logic [NCH-1:0] signSnap;

    always_ff @(posedge clk) begin
        if (srst) begin
            qHeld <= '0;
            signSnap <= '0;
        end else begin
            if (qUpdate) begin
                qHeld <= qNegative;
            end
            if (windowEnd) begin
                signSnap <= qUpdate ? qNegative : qHeld;
            end
        end
    end

    // ************************************************************
    // Result sequencer
    // ************************************************************
    rpc_state_e state;
    logic [1:0] ch;
    logic [1:0] op;
    logic [RW-1:0] meanVV;
    logic [RW-1:0] meanII;
    logic [RW-1:0] magP;
    logic negP;
    logic [RW-1:0] radicand;
    logic rootStart;
    logic rootDone;
    logic [HW-1:0] root;
    rpc_report_s work;
    rpc_report_s mapCopy;
    logic [2*RW-1:0] sqS;
    logic [2*RW-1:0] sqP;

    assign sqS = (2*RW)'(meanVV) * (2*RW)'(meanII);
    assign sqP = (2*RW)'(magP) * (2*RW)'(magP);
    assign rootStart = (state == S_ROOT);

    always_comb begin
        case (op)
            2'h0: radicand = meanVV;
            2'h1: radicand = meanII;
            2'h2: radicand = RW'(sqS);
            default: radicand = (sqS > sqP) ? RW'(sqS - sqP) : '0;
        endcase
    end

    rpc_isqrt #(.W(RW)) u_root (
        .clk(clk),
        .srst(srst),
        .start(rootStart),
        .radicand(radicand),
        .done(rootDone),
        .root(root)
    );

    always_ff @(posedge clk) begin
        if (srst) begin
            state <= S_IDLE;
            ch <= '0;
            op <= '0;
            meanVV <= '0;
            meanII <= '0;
            magP <= '0;
            negP <= 1'b0;
            work <= '0;
        end else begin
            case (state)
                S_IDLE: begin
                    if (windowEnd) begin
                        ch <= '0;
                        state <= S_PREP;
                    end
                end
                S_PREP: begin
                    meanVV <= meanOf(sumVV[ch], recip);
                    meanII <= meanOf(sumII[ch], recip);
                    negP <= sumVI[ch][63];
                    magP <= meanOf(sumVI[ch][63] ? -sumVI[ch] : sumVI[ch], recip);
                    op <= '0;
                    state <= S_ROOT;
                end
                S_ROOT: begin
                    state <= S_WAIT;
                end
                S_WAIT: begin
                    if (rootDone) begin
                        case (op)
                            2'h0: work.val[ch*NQ+Q_VRMS] <= toFloat(RW'(root), 1'b0);
                            2'h1: work.val[ch*NQ+Q_IRMS] <= toFloat(RW'(root), 1'b0);
                            2'h2: work.val[ch*NQ+Q_SRMS] <= toFloat(RW'(root), 1'b0);
                            default: work.val[ch*NQ+Q_NRMS] <= toFloat(RW'(root), signSnap[ch]);
                        endcase
                        work.val[ch*NQ+Q_PRMS] <= toFloat(magP, negP);
                        if (op != 2'h3) begin
                            op <= op + 1'b1;
                            state <= S_ROOT;
                        end else if (ch != 2'(NCH - 1)) begin
                            ch <= ch + 1'b1;
                            state <= S_PREP;
                        end else begin
                            state <= S_PUBLISH;
                        end
                    end
                end
                default: begin
                    state <= S_IDLE;
                end
            endcase
        end
    end

    // ************************************************************
    // Publishing
    // ************************************************************
    always_ff @(posedge clk) begin
        if (srst) begin
            streamValid <= 1'b0;
            streamData <= '0;
            mapCopy <= '0;
        end else begin
            streamValid <= (state == S_PUBLISH);
            if (state == S_PUBLISH) begin
                streamData <= work;
                mapCopy <= work;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            mapData <= '0;
        end else begin
            mapData <= (mapAddr < ADDR_W'(NCH * NQ)) ? mapCopy.val[mapAddr] : '0;
        end
    end

    // ************************************************************
    // Checks
    // ************************************************************
    property p_tickRate;
        @(posedge clk) disable iff (srst)
        sampleReq |=> !sampleReq [*8];
    endproperty
    a_tickRate: assert property (p_tickRate) else $error("sample tick too frequent");

    property p_windowLen;
        @(posedge clk) disable iff (srst)
        windowEnd |-> (32'(sampleCnt) + 1 == 32'(winLen)) && (winLen != '0);
    endproperty
    a_windowLen: assert property (p_windowLen) else $error("window length wrong");

    property p_accClear;
        @(posedge clk) disable iff (srst)
        windowEnd |=> (accVV == '0) && (accII == '0) && (accVI == '0);
    endproperty
    a_accClear: assert property (p_accClear) else $error("accumulators not cleared");

    property p_resultInTime;
        @(posedge clk) disable iff (srst)
        windowEnd |-> ##[1:1000] streamValid;
    endproperty
    a_resultInTime: assert property (p_resultInTime) else $error("results late");

    property p_mapHold;
        @(posedge clk) disable iff (srst)
        (state != S_PUBLISH) |=> $stable(mapCopy);
    endproperty
    a_mapHold: assert property (p_mapHold) else $error("map changed mid window");

    property p_rmsPositive;
        @(posedge clk) disable iff (srst)
        streamValid |-> !streamData.val[Q_VRMS][31] && !streamData.val[Q_IRMS][31];
    endproperty
    a_rmsPositive: assert property (p_rmsPositive) else $error("rms sign set");

    property p_nonActiveSign;
        @(posedge clk) disable iff (srst)
        (streamValid && streamData.val[Q_NRMS] != '0)
            |-> streamData.val[Q_NRMS][31] == signSnap[0];
    endproperty
    a_nonActiveSign: assert property (p_nonActiveSign) else $error("Q sign lost");

    property p_streamPulse;
        @(posedge clk) disable iff (srst)
        streamValid |=> !streamValid && (streamData == mapCopy);
    endproperty
    a_streamPulse: assert property (p_streamPulse) else $error("stream pulse wrong");
endmodule
`default_nettype wire

/* tb/rpc_src_model.sv */
// Behavioural model of the sample acquisition path and the reactive sign source.
`timescale 1ns/1ps
`default_nettype none
module rpc_src_model
    import rpc_pkg::*;
#(
    parameter int QPERIOD = CLK_HZ / QSIGN_RATE_HZ
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic sampleReq,
    output rpc_sample_s samples,
    output logic qUpdate,
    output logic [NCH-1:0] qNegative
);
    rpc_sample_s good;
    int qCount;

    // ************************************************************
    // Sample lines
    // ************************************************************
    // Outside the capture cycle the lines carry the inverse, so a stray capture is visible.
    always_comb begin
        samples = sampleReq ? good : ~good;
    end

    // Voltage and current of one channel move together, as one time-aligned pair.
    always @(posedge clk) begin
        if (srst) begin
            good <= '0;
        end else if (sampleReq) begin
            for (int c = 0; c < NCH; c++) begin
                good.volt[c] <= good.volt[c] + VW'(c + 1);
                good.curr[c] <= good.curr[c] - IW'(c + 1);
            end
        end
    end

    // ************************************************************
    // Reactive sign estimate
    // ************************************************************
    always @(posedge clk) begin
        if (srst) begin
            qCount <= 0;
            qUpdate <= 1'b0;
            qNegative <= 4'h5;
        end else if (qCount == QPERIOD - 1) begin
            qCount <= 0;
            qUpdate <= 1'b1;
            qNegative <= ~qNegative;
        end else begin
            qCount <= qCount + 1;
            qUpdate <= 1'b0;
        end
    end
endmodule
`default_nettype wire

/* tb/test_rpc_calc.sv */
// Self-checking testbench of the RMS and power calculator.
`timescale 1ns/1ps
`default_nettype none
module test_rpc_calc;
    import rpc_pkg::*;

    logic clk;
    logic srst;
    rpc_int_e intSel;
    rpc_sample_s samples;
    logic qUpdate;
    logic [NCH-1:0] qNegative;
    logic [ADDR_W-1:0] mapAddr;
    logic sampleReq;
    logic streamValid;
    rpc_report_s streamData;
    rpc_float_t mapData;
    int bad_count;
    int cmp_count;
    logic resultsAllowed;

    // A short tick keeps a full 100 ms window of samples inside the run budget.
    localparam int TB_TICKS = 20;

    rpc_calc #(.TICKS(TB_TICKS)) DUT (
        .clk(clk),
        .srst(srst),
        .intSel(intSel),
        .samples(samples),
        .qUpdate(qUpdate),
        .qNegative(qNegative),
        .mapAddr(mapAddr),
        .sampleReq(sampleReq),
        .streamValid(streamValid),
        .streamData(streamData),
        .mapData(mapData)
    );

    rpc_src_model src (
        .clk(clk),
        .srst(srst),
        .sampleReq(sampleReq),
        .samples(samples),
        .qUpdate(qUpdate),
        .qNegative(qNegative)
    );

    // ************************************************************
    // Clock and shared tasks
    // ************************************************************
    initial begin
        clk = 1'b0;
    end
    always #12.5 clk = ~clk;

    task automatic test_done();
        if (bad_count == 0 && cmp_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic check(input logic [$bits(rpc_report_s)-1:0] seen,
                         input logic [$bits(rpc_report_s)-1:0] expected, input string what);
        cmp_count++;
        if (seen !== expected) begin
            bad_count++;
            $display("FAIL at %0t: %s is %0h, expected %0h", $time, what, seen, expected);
        end
    endtask

    task automatic step();
        @(posedge clk);
        #1;
    endtask

    // Counts edges until a sample request is seen, with a bound of two tick periods.
    task automatic wait_req(output int n);
        n = 0;
        while (sampleReq !== 1'b1) begin
            step();
            n++;
            if (n > 2 * TB_TICKS) begin
                bad_count++;
                $display("FAIL at %0t: no sample request", $time);
                test_done();
            end
        end
    endtask

    task automatic check_quiet_outputs();
        check(sampleReq, 1'b0, "sampleReq");
        check(streamValid, 1'b0, "streamValid");
        check(streamData, '0, "streamData");
        check(mapData, '0, "mapData");
    endtask

    // Results must not appear before the window scenario expects the first one.
    always @(negedge clk) begin
        if (srst === 1'b0 && !resultsAllowed) begin
            check(streamValid, 1'b0, "early streamValid");
        end
    end

    // ************************************************************
    // Scenarios
    // ************************************************************
    task automatic scen_reset_and_first_tick();
        int n;
        srst = 1'b1;
        repeat (5) step();
        check_quiet_outputs();
        srst = 1'b0;
        wait_req(n);
        check(n, TB_TICKS - 1, "edges to first request");
    endtask

    // Every window setting is visited while the tick spacing is measured.
    task automatic scen_tick_spacing();
        int n;
        for (int k = 0; k < 4; k++) begin
            intSel = rpc_int_e'(k);
            step();
            check(sampleReq, 1'b0, "request width");
            wait_req(n);
            check(n + 1, TB_TICKS, "request spacing");
        end
    endtask

    // Before any window has ended the map copy must read zero everywhere.
    task automatic scen_map_sweep();
        for (int a = 0; a < 32; a++) begin
            mapAddr = ADDR_W'(a);
            step();
            check(mapData, '0, "map before first window");
        end
    endtask

    // A reset early in a tick period must restart the tick and the window from zero.
    task automatic scen_midrun_reset();
        int n;
        step();
        repeat (TB_TICKS - 10) step();
        srst = 1'b1;
        step();
        check_quiet_outputs();
        srst = 1'b0;
        wait_req(n);
        check(n, TB_TICKS - 1, "edges after second reset");
        step();
        wait_req(n);
        check(n + 1, TB_TICKS, "spacing after second reset");
    endtask

    // Anti-phase samples make S equal to |P|, Vrms equal to Irms and N zero on every channel.
    task automatic scen_first_window();
        int n;
        rpc_report_s seen;
        n = 0;
        intSel = INT_100MS;
        resultsAllowed = 1'b1;
        while (streamValid !== 1'b1) begin
            step();
            n++;
            if (n > windowLen(INT_100MS) * TB_TICKS + 1000) begin
                bad_count++;
                $display("FAIL at %0t: no result after a window", $time);
                test_done();
            end
        end
        seen = streamData;
        step();
        check(streamValid, 1'b0, "result pulse width");
        for (int c = 0; c < NCH; c++) begin
            check(seen.val[c*NQ+Q_VRMS] == '0, 1'b0, "Vrms zero");
            check(seen.val[c*NQ+Q_IRMS], seen.val[c*NQ+Q_VRMS], "Irms vs Vrms");
            check(seen.val[c*NQ+Q_PRMS][31], 1'b1, "P sign");
            check(seen.val[c*NQ+Q_SRMS], {1'b0, seen.val[c*NQ+Q_PRMS][30:0]}, "S vs P");
            check(seen.val[c*NQ+Q_NRMS], '0, "N of aligned pair");
        end
        for (int a = 0; a < NCH * NQ; a++) begin
            mapAddr = ADDR_W'(a);
            step();
            check(mapData, seen.val[a], "map copy");
        end
    endtask

    initial begin
        bad_count = 0;
        cmp_count = 0;
        resultsAllowed = 1'b0;
        srst = 1'b1;
        intSel = INT_100MS;
        mapAddr = '0;
        scen_reset_and_first_tick();
        scen_tick_spacing();
        scen_map_sweep();
        scen_midrun_reset();
        scen_first_window();
        test_done();
    end
endmodule
`default_nettype wire
